// file: hw/remote_temp_result_formatter.sv
// Remote and local temperature result formatting and bus address strap
//
// How it works
// - Whole degrees are an 8-bit two's complement byte, one degree per step.
// - Remote fraction is three bits at 0.125 degree steps, 000 to 111.
// - Local fraction is two bits at 0.25 degree steps, 00 to 11.
// - Both fraction fields sit together in the register at offset 0x06.
// - Remote result is 11-bit two's complement: byte high, three fraction bits low.
// - Remote result is the average of sixteen consecutive measurement cycles.
// - One averaged remote measurement takes nominally 9.6 ms.
// - Remote step is 0.125 degree, span reaching up to 127.875 degrees.
// - Address strap sampled only after power-up, fixes two low address bits.
// - Upper five address bits are fixed at 01011.
// - Strap ground gives 00, open gives 10, supply gives 01.
// - Local result is 10-bit two's complement with quarter-degree fraction.
`timescale 1ns/100ps
module remote_temp_result_formatter
	import temp_fmt_pkg::*;
#(
	parameter int MEAS_CYCLE = MEAS_CYCLE_CLKS
) (
	// Clock and reset
	input  wire logic                clock_i,
	input  wire logic                resetn_i,
	// Strap pad comparators
	input  wire logic                strap_sense_hi_i,
	input  wire logic                strap_sense_lo_i,
	// Converter results and measurement request
	input  wire logic [REMOTE_W-1:0] remote_sample_i,
	input  wire logic                remote_valid_i,
	input  wire logic [LOCAL_W-1:0]  local_sample_i,
	input  wire logic                local_valid_i,
	output logic                     meas_start_o,
	// Register read port
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic                reg_rd_i,
	output logic [7:0]               reg_rdata_o,
	// Bus address
	output logic [6:0]               bus_addr_o,
	output logic                     strap_done_o
);
	logic [REMOTE_W-1:0] remote_ff, nxt_remote;
	logic [LOCAL_W-1:0]  local_ff, nxt_local;
	logic [7:0]          rdata_ff, nxt_rdata;
	logic [16:0]         tick_ff, nxt_tick;
	logic                start_ff, nxt_start;
	logic [1:0]          hi_sync_ff, lo_sync_ff;
	logic [1:0]          settle_ff, nxt_settle;
	logic                done_ff, nxt_done;
	logic [6:0]          addr_ff, nxt_addr;
	logic                strap_high_bit, strap_low_bit;

	avg_if link ();

	remote_averager u_avg (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.link     (link)
	);

	assign link.sample       = remote_sample_i;
	assign link.sample_valid = remote_valid_i;

	function automatic logic [7:0] frac_byte(input logic [REMOTE_W-1:0] r,
		input logic [LOCAL_W-1:0] l);
		logic [7:0] b;
		b = 8'h00;
		b[FRAC_REMOTE_POS +: REMOTE_FRAC_W] = r[REMOTE_FRAC_W-1:0];
		b[FRAC_LOCAL_POS +: LOCAL_FRAC_W]   = l[LOCAL_FRAC_W-1:0];
		return b;
	endfunction : frac_byte

	always_comb begin
		nxt_start = 1'b0;
		nxt_tick  = tick_ff + 17'h00001;
		if (tick_ff == 17'(MEAS_CYCLE - 1)) begin
			nxt_tick  = 17'h00000;
			nxt_start = 1'b1;
		end
	end

	always_comb begin
		nxt_remote = remote_ff;
		nxt_local  = local_ff;
		if (link.result_valid) begin
			nxt_remote = link.result;
		end
		if (local_valid_i) begin
			nxt_local = local_sample_i;
		end
	end

	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				// upper eight bits are whole degrees
				REG_REMOTE_HIGH: nxt_rdata = remote_ff[REMOTE_W-1 -: 8];
				REG_LOCAL_HIGH:  nxt_rdata = local_ff[LOCAL_W-1 -: 8];
				REG_FRAC:        nxt_rdata = frac_byte(remote_ff, local_ff);
				default:         nxt_rdata = 8'h00;
			endcase
		end
	end

	always_comb begin
		// Only the second sync stage is read; the raw pad may be mid-transition
		strap_high_bit = !hi_sync_ff[1] & !lo_sync_ff[1];
		strap_low_bit  = hi_sync_ff[1] & !lo_sync_ff[1];
	end

	always_comb begin
		nxt_settle = settle_ff;
		nxt_done   = done_ff;
		nxt_addr   = addr_ff;
		if (!done_ff) begin
			nxt_settle = settle_ff + 2'h1;
			if (settle_ff == 2'(STRAP_SETTLE_CLKS - 1)) begin
				nxt_done = 1'b1;
				nxt_addr = {BUS_ADDR_UPPER, strap_high_bit, strap_low_bit};
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			remote_ff  <= REMOTE_RESET;
			local_ff   <= LOCAL_RESET;
			rdata_ff   <= RDATA_RESET;
			tick_ff    <= 17'h00000;
			start_ff   <= 1'b0;
			hi_sync_ff <= 2'h0;
			lo_sync_ff <= 2'h0;
			settle_ff  <= 2'h0;
			done_ff    <= 1'b0;
			addr_ff    <= {BUS_ADDR_UPPER, STRAP_GND};
		end else begin
			remote_ff  <= nxt_remote;
			local_ff   <= nxt_local;
			rdata_ff   <= nxt_rdata;
			tick_ff    <= nxt_tick;
			start_ff   <= nxt_start;
			hi_sync_ff <= {hi_sync_ff[0], strap_sense_hi_i};
			lo_sync_ff <= {lo_sync_ff[0], strap_sense_lo_i};
			settle_ff  <= nxt_settle;
			done_ff    <= nxt_done;
			addr_ff    <= nxt_addr;
		end
	end

	assign meas_start_o = start_ff;
	assign reg_rdata_o  = rdata_ff;
	assign bus_addr_o   = addr_ff;
	assign strap_done_o = done_ff;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	sequence s_result_out;
		link.result_valid;
	endsequence
	sequence s_published;
		remote_ff == $past(link.result);
	endsequence
	sequence s_capture;
		!done_ff && nxt_done;
	endsequence

	a_remote_pub_whole: assert property (s_result_out |=> s_published)
		else $error("remote result not published whole");
	a_local_pub_whole: assert property (
		local_valid_i |=> local_ff == $past(local_sample_i))
		else $error("local result not published");
	a_frac_read: assert property (
		reg_rd_i && reg_addr_i == 8'h06 |=>
		reg_rdata_o[7:5] == $past(remote_ff[2:0]) && reg_rdata_o[4:3] == $past(local_ff[1:0]))
		else $error("fraction register wrong");
	a_remote_high_read: assert property (
		reg_rd_i && reg_addr_i == REG_REMOTE_HIGH |=> reg_rdata_o == $past(remote_ff[10:3]))
		else $error("remote high byte wrong");
	a_addr_upper: assert property (
		done_ff |-> bus_addr_o[6:2] == 5'b01011)
		else $error("upper address bits wrong");
	a_addr_frozen: assert property (strap_done_o |=> $stable(bus_addr_o))
		else $error("address changed after strap capture");
	a_strap_open: assert property (
		!done_ff && nxt_done && !hi_sync_ff[1] && !lo_sync_ff[1] |=> bus_addr_o == 7'b0101110)
		else $error("open strap address wrong");
	a_tick_period: assert property (
		meas_start_o |=> !meas_start_o [*8])
		else $error("measurement cycles too close");
	a_tick_count: assert property (
		meas_start_o |-> tick_ff == 17'h00000)
		else $error("measurement pacing counter off");
	a_tick_bound: assert property (tick_ff <= 17'(MEAS_CYCLE - 1))
		else $error("measurement pacing counter overran");

	a_strap_ground: assert property (
		s_capture ##0 (lo_sync_ff[1] && !hi_sync_ff[1]) |=> bus_addr_o[1:0] == STRAP_GND)
		else $error("grounded strap address wrong");
	a_strap_supply: assert property (
		s_capture ##0 (hi_sync_ff[1] && !lo_sync_ff[1]) |=> bus_addr_o[1:0] == STRAP_VCC)
		else $error("supply strap address wrong");
	a_done_sticky: assert property (strap_done_o |=> strap_done_o)
		else $error("strap capture flag dropped");
	a_local_high_read: assert property (
		reg_rd_i && reg_addr_i == REG_LOCAL_HIGH |=> reg_rdata_o == $past(local_ff[9:2]))
		else $error("local high byte wrong");
	a_frac_spare_zero: assert property (
		reg_rd_i && reg_addr_i == REG_FRAC |=> reg_rdata_o[2:0] == 3'h0)
		else $error("fraction register spare bits set");
	a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_remote_hold: assert property (!link.result_valid |=> $stable(remote_ff))
		else $error("remote result changed between averages");
endmodule : remote_temp_result_formatter

// file: hw/temp_fmt_pkg.sv
// Constants shared by the temperature result formatter
package temp_fmt_pkg;
	// Clock and measurement timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int MEAS_TIME_NS    = 9_600_000;
	localparam int AVG_SAMPLES     = 16;
	localparam int AVG_SHIFT       = 4;
	localparam int MEAS_CYCLE_CLKS = MEAS_TIME_NS / (CLK_PERIOD_NS * AVG_SAMPLES);
	localparam int STRAP_SETTLE_CLKS = 3;
	// Data widths
	localparam int REMOTE_W      = 11;
	localparam int LOCAL_W       = 10;
	localparam int REMOTE_FRAC_W = 3;
	localparam int LOCAL_FRAC_W  = 2;
	localparam int SUM_W         = REMOTE_W + AVG_SHIFT;
	// Register offsets
	localparam logic [7:0] REG_FRAC        = 8'h06;
	localparam logic [7:0] REG_LOCAL_HIGH  = 8'h0A;
	localparam logic [7:0] REG_REMOTE_HIGH = 8'h0B;
	// Fraction register field positions (low bit of each field)
	localparam int FRAC_REMOTE_POS = 5;
	localparam int FRAC_LOCAL_POS  = 3;
	// Reset values
	localparam logic [REMOTE_W-1:0] REMOTE_RESET = 11'h000;
	localparam logic [LOCAL_W-1:0]  LOCAL_RESET  = 10'h000;
	localparam logic [7:0]          RDATA_RESET  = 8'h00;
	// Serial bus address
	localparam logic [4:0] BUS_ADDR_UPPER = 5'h0B;
	localparam logic [1:0] STRAP_GND      = 2'h0;
	localparam logic [1:0] STRAP_VCC      = 2'h1;
	localparam logic [1:0] STRAP_OPEN     = 2'h2;
endpackage : temp_fmt_pkg

// file: hw/avg_if.sv
// Sample and result link between the formatter and its averager
`timescale 1ns/100ps
interface avg_if;
	import temp_fmt_pkg::*;
	logic [REMOTE_W-1:0] sample;
	logic                sample_valid;
	logic [REMOTE_W-1:0] result;
	logic                result_valid;
	modport src (output sample, output sample_valid, input result, input result_valid);
	modport avg (input sample, input sample_valid, output result, output result_valid);
endinterface : avg_if

// file: hw/remote_averager.sv
// Sixteen-sample averager for remote conversions
`timescale 1ns/100ps
module remote_averager
	import temp_fmt_pkg::*;
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic resetn_i,
	// Sample link
	avg_if.avg        link
);
	logic signed [SUM_W-1:0]  sum_ff, nxt_sum;
	logic [AVG_SHIFT-1:0]     cnt_ff, nxt_cnt;
	logic [REMOTE_W-1:0]      res_ff, nxt_res;
	logic                     rv_ff, nxt_rv;
	logic signed [SUM_W-1:0]  sum_new;

	always_comb begin
		sum_new = sum_ff + SUM_W'(signed'(link.sample));
		nxt_sum = sum_ff;
		nxt_cnt = cnt_ff;
		nxt_res = res_ff;
		nxt_rv  = 1'b0;
		if (link.sample_valid) begin
			nxt_cnt = cnt_ff + 1'b1;
			nxt_sum = sum_new;
			if (cnt_ff == AVG_SHIFT'(AVG_SAMPLES - 1)) begin
				// Arithmetic shift keeps the sign of negative readings
				nxt_res = REMOTE_W'(sum_new >>> AVG_SHIFT);
				nxt_rv  = 1'b1;
				nxt_sum = '0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sum_ff <= '0;
			cnt_ff <= '0;
			res_ff <= REMOTE_RESET;
			rv_ff  <= 1'b0;
		end else begin
			sum_ff <= nxt_sum;
			cnt_ff <= nxt_cnt;
			res_ff <= nxt_res;
			rv_ff  <= nxt_rv;
		end
	end

	assign link.result       = res_ff;
	assign link.result_valid = rv_ff;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	a_avg_after_sixteen: assert property (
		link.result_valid |-> $past(link.sample_valid) && $past(cnt_ff) == 4'hF)
		else $error("average published before sixteen samples");
endmodule : remote_averager

// file: dv/diode_sensor_model.sv
// Behavioural remote sensor and converter answering measurement requests
`timescale 1ns/100ps
module diode_sensor_model
	import temp_fmt_pkg::*;
(
	// Clock and reset
	input  wire logic                clock_i,
	input  wire logic                resetn_i,
	// Request and settings
	input  wire logic                start_i,
	input  wire logic [REMOTE_W-1:0] temp_i,
	input  wire logic                jitter_i,
	input  wire logic [3:0]          lag_i,
	// Result
	output logic [REMOTE_W-1:0]      sample_o,
	output logic                     valid_o
);
	logic       pend_ff;
	logic       odd_ff;
	logic [3:0] wait_ff;

	always @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pend_ff  <= 1'b0;
			odd_ff   <= 1'b0;
			wait_ff  <= 4'h0;
			valid_o  <= 1'b0;
			sample_o <= '0;
		end else begin
			valid_o  <= 1'b0;
			// Released data inverts every cycle so a sample taken one cycle late never looks right
			sample_o <= ~sample_o;
			if (start_i) begin
				pend_ff <= 1'b1;
				wait_ff <= lag_i;
			end else if (pend_ff && wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1;
			end else if (pend_ff) begin
				pend_ff  <= 1'b0;
				valid_o  <= 1'b1;
				sample_o <= temp_i + {10'h000, jitter_i & odd_ff};
				odd_ff   <= ~odd_ff;
			end
		end
	end
endmodule : diode_sensor_model

// file: dv/remote_temp_result_formatter_test.sv
// Self-checking bench for the remote temperature result formatter
`timescale 1ns/100ps
module remote_temp_result_formatter_test;
	import temp_fmt_pkg::*;
	localparam int MC = 20;
	localparam logic [10:0] RT [4] = '{11'h400, 11'h3FE, 11'h001, 11'h7FF};
	localparam logic [9:0]  LT [4] = '{10'h200, 10'h1FF, 10'h005, 10'h3FE};
	localparam logic [1:0]  ST [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
	localparam logic [1:0]  SB [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
	logic                clock_i  = 1'b0;
	logic                resetn_i = 1'b0;
	logic                s_hi     = 1'b0;
	logic                s_lo     = 1'b0;
	logic [REMOTE_W-1:0] r_smp;
	logic                r_vld;
	logic [LOCAL_W-1:0]  l_smp    = '0;
	logic                l_vld    = 1'b0;
	logic                m_start;
	logic [7:0]          addr     = 8'h00;
	logic                rd       = 1'b0;
	logic [7:0]          rdata;
	logic [6:0]          bus_addr;
	logic                s_done;
	logic [REMOTE_W-1:0] temp     = '0;
	logic                jit      = 1'b0;
	logic [3:0]          lag      = 4'h0;
	int                  fails    = 0;
	int                  checks   = 0;

	remote_temp_result_formatter #(.MEAS_CYCLE(MC)) dut_u (
		.clock_i(clock_i), .resetn_i(resetn_i),
		.strap_sense_hi_i(s_hi), .strap_sense_lo_i(s_lo),
		.remote_sample_i(r_smp), .remote_valid_i(r_vld),
		.local_sample_i(l_smp), .local_valid_i(l_vld), .meas_start_o(m_start),
		.reg_addr_i(addr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.bus_addr_o(bus_addr), .strap_done_o(s_done));
	diode_sensor_model model_u (
		.clock_i(clock_i), .resetn_i(resetn_i), .start_i(m_start), .temp_i(temp),
		.jitter_i(jit), .lag_i(lag), .sample_o(r_smp), .valid_o(r_vld));

	always #4 clock_i = ~clock_i;

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		@(posedge clock_i);
		#1 rd = 1'b0;
		cmp(rdata, exp, "read");
		@(posedge clock_i);
		#1;
	endtask : rd_chk

	task automatic summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		summarize();
	end

	initial begin
		int n;
		for (int k = 0; k < 4; k++) begin
			resetn_i = 1'b0;
			{s_hi, s_lo} = ST[k];
			temp = RT[k];
			jit = (k == 3);
			lag = (k == 1) ? 4'hF : 4'(k * 3);
			repeat (12) @(posedge clock_i);
			#1 cmp({1'b0, bus_addr}, {1'b0, 5'h0B, 2'h0}, "reset address");
			resetn_i = 1'b1;
			n = 0;
			while (s_done !== 1'b1 && n < 10) begin
				@(posedge clock_i);
				#1 n++;
			end
			cmp({7'h00, s_done}, 8'h01, "strap done");
			cmp({1'b0, bus_addr}, {1'b0, 5'h0B, SB[k]}, "address");
			// Strap moves after capture and must be ignored
			{s_hi, s_lo} = ~ST[k];
			n = 0;
			while (n < 16) begin
				@(posedge clock_i);
				#1 if (r_vld === 1'b1)
					n++;
			end
			repeat (3) @(posedge clock_i);
			#1 cmp({1'b0, bus_addr}, {1'b0, 5'h0B, SB[k]}, "address held");
			l_smp = LT[k];
			l_vld = 1'b1;
			@(posedge clock_i);
			#1 l_vld = 1'b0;
			// With jitter the mean is t+0.5, which must floor back to t
			rd_chk(8'h0B, RT[k][10:3]);
			rd_chk(8'h0A, LT[k][9:2]);
			rd_chk(8'h06, {RT[k][2:0], LT[k][1:0], 3'h0});
			rd_chk(8'h07, 8'h00);
			n = 0;
			@(posedge m_start);
			do begin
				@(posedge clock_i);
				#1 n++;
			end while (m_start !== 1'b1 && n < 100);
			cmp(8'(n), 8'(MC), "request period");
			$display("test %0d done", k);
		end
		summarize();
	end
endmodule : remote_temp_result_formatter_test
